// >>> hw/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam int         ADDR_W       = 8;
  localparam logic [5:0] IDX_CTRL     = 6'h00;
  localparam logic [5:0] IDX_WINMODE  = 6'h04;
  localparam logic [5:0] IDX_SAMPEXT  = 6'h05;
  localparam logic [5:0] IDX_INSEL    = 6'h06;
  localparam logic [5:0] IDX_CMD      = 6'h08;
  localparam logic [5:0] IDX_EVTRIG   = 6'h09;
  localparam logic [5:0] IDX_IRQEN    = 6'h0a;
  localparam logic [5:0] IDX_IRQFLAGS = 6'h0b;
  localparam logic [5:0] IDX_RESL     = 6'h10;
  localparam logic [5:0] IDX_RESH     = 6'h11;
  localparam logic [5:0] IDX_LTL      = 6'h12;
  localparam logic [5:0] IDX_LTH      = 6'h13;
  localparam logic [5:0] IDX_HTL      = 6'h14;
  localparam logic [5:0] IDX_HTH      = 6'h15;

  ////////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int BIT_CONTINUOUS = 1;
  localparam int BIT_START      = 0;
  localparam int BIT_EVSTART    = 0;
  localparam int BIT_WMATCH     = 1;
  localparam int BIT_RREADY     = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [2:0]  RST_WINMODE = 3'h0;
  localparam logic [4:0]  RST_SAMPEXT = 5'h00;
  localparam logic [4:0]  RST_INSEL   = 5'h00;
  localparam logic [15:0] RST_THRESH  = 16'h0000;
  localparam logic [1:0]  RST_IRQ     = 2'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // window compare modes and input codes
  localparam logic [2:0] WIN_NONE    = 3'h0;
  localparam logic [2:0] WIN_BELOW   = 3'h1;
  localparam logic [2:0] WIN_ABOVE   = 3'h2;
  localparam logic [2:0] WIN_INSIDE  = 3'h3;
  localparam logic [2:0] WIN_OUTSIDE = 3'h4;
  localparam logic [4:0] CH_PIN_LAST = 5'h0b;
  localparam logic [4:0] CH_SPECIAL  = 5'h1b;
  localparam logic [4:0] CH_DAC      = 5'h1c;
  localparam logic [4:0] CH_INTREF   = 5'h1d;
  localparam logic [4:0] CH_GND      = 5'h1f;

  ////////////////////////////////////////////////////////////////////////////////
  // timing counts, in conversion-clock cycles; the divider in clock cycles per conversion clock
  localparam int SAMPLE_BASE_CYCLES = 2;
  localparam int CONV_CYCLES_DEF    = 11;
  localparam int CLK_DIV_DEF        = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic windowMatch;
    logic resultReady;
  } irq_bits_s;

endpackage

// >>> hw/adc_window_trigger_irq_ctrl.sv
// The AXI4-Lite interface to the registers was chosen for this implementation.
module adc_window_trigger_irq_ctrl #(
  parameter int CLK_DIV     = adc_ctrl_pkg::CLK_DIV_DEF,     // clock to conversion clock
  parameter int CONV_CYCLES = adc_ctrl_pkg::CONV_CYCLES_DEF  // conversion phase length
) (
  input  wire logic        clock,          // 125 MHz
  input  wire logic        reset,          // async, active high
  input  wire logic [7:0]  awaddr,         // write address
  input  wire logic        awvalid,        // write address valid
  output logic             awready,        // write address ready
  input  wire logic [31:0] wdata,          // write data
  input  wire logic [3:0]  wstrb,          // write strobes
  input  wire logic        wvalid,         // write data valid
  output logic             wready,         // write data ready
  output logic [1:0]       bresp,          // write response
  output logic             bvalid,         // write response valid
  input  wire logic        bready,         // write response ready
  input  wire logic [7:0]  araddr,         // read address
  input  wire logic        arvalid,        // read address valid
  output logic             arready,        // read address ready
  output logic [31:0]      rdata,          // read data
  output logic [1:0]       rresp,          // read response
  output logic             rvalid,         // read data valid
  input  wire logic        rready,         // read data ready
  input  wire logic        startEvent,     // event input, one-cycle pulse
  input  wire logic [15:0] convResult,     // accumulated value from the analog core
  output logic [4:0]       inputSelect,    // channel routed to the converter
  output logic             inputLegal,     // routed code is a defined source
  output logic             sampling,       // sampling phase active
  output logic             converting,     // conversion in progress
  output logic             convDone,       // completion pulse
  output logic             irq             // level interrupt
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic regHit(input logic [5:0] idx);
    regHit = idx inside {adc_ctrl_pkg::IDX_CTRL, adc_ctrl_pkg::IDX_WINMODE,
                         adc_ctrl_pkg::IDX_SAMPEXT, adc_ctrl_pkg::IDX_INSEL,
                         adc_ctrl_pkg::IDX_CMD, adc_ctrl_pkg::IDX_EVTRIG,
                         adc_ctrl_pkg::IDX_IRQEN, adc_ctrl_pkg::IDX_IRQFLAGS,
                         adc_ctrl_pkg::IDX_RESL, adc_ctrl_pkg::IDX_RESH,
                         adc_ctrl_pkg::IDX_LTL, adc_ctrl_pkg::IDX_LTH,
                         adc_ctrl_pkg::IDX_HTL, adc_ctrl_pkg::IDX_HTH};
  endfunction

  function automatic logic winMatch(input logic [2:0] mode, input logic [15:0] value,
                                    input logic [15:0] lo, input logic [15:0] hi);
    case (mode)
      adc_ctrl_pkg::WIN_BELOW:   winMatch = value < lo;
      adc_ctrl_pkg::WIN_ABOVE:   winMatch = value > hi;
      adc_ctrl_pkg::WIN_INSIDE:  winMatch = (value > lo) && (value < hi);
      adc_ctrl_pkg::WIN_OUTSIDE: winMatch = (value < lo) || (value > hi);
      default:                   winMatch = 1'b0;
    endcase
  endfunction

  function automatic logic chanLegal(input logic [4:0] code);
    chanLegal = (code <= adc_ctrl_pkg::CH_PIN_LAST) ||
                (code inside {adc_ctrl_pkg::CH_SPECIAL, adc_ctrl_pkg::CH_DAC,
                              adc_ctrl_pkg::CH_INTREF, adc_ctrl_pkg::CH_GND});
  endfunction

  localparam int         DIV_W     = (CLK_DIV > 1) ? $clog2(CLK_DIV) : 1;
  localparam logic [5:0] CONV_LAST = 6'(CONV_CYCLES - 1);

  typedef enum logic [1:0] {IDLE, SAMPLE, CONVERT} conv_state_e;

  ////////////////////////////////////////////////////////////////////////////////
  // register and state declarations

  logic                    continuous_q;
  logic [2:0]              winMode_q;
  logic [4:0]              sampExt_q;
  logic [4:0]              inSel_q;
  logic                    evStart_q;
  adc_ctrl_pkg::irq_bits_s irqEn_q;
  adc_ctrl_pkg::irq_bits_s flags_q;
  adc_ctrl_pkg::irq_bits_s flags_d;
  logic [15:0]             result_q;
  logic [15:0]             lowThr_q;
  logic [15:0]             highThr_q;
  conv_state_e             state_q;
  logic [DIV_W-1:0]        divCnt_q;
  logic [5:0]              phaseCnt_q;
  logic [5:0]              sample_extend_q;
  logic [4:0]              chan_q;

  logic                    awHeld_q;
  logic [7:0]              awAddr_q;
  logic                    wHeld_q;
  logic [7:0]              wByte_q;
  logic                    wLane_q;
  logic                    bvalid_q;
  logic [1:0]              bresp_q;
  logic                    rvalid_q;
  logic [31:0]             rdata_q;
  logic [1:0]              rresp_q;

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode

  wire       doWrite  = awHeld_q && wHeld_q && !bvalid_q;
  wire [5:0] wrIdx    = awAddr_q[7:2];
  wire       wrHit    = (awAddr_q[1:0] == 2'h0) && regHit(wrIdx);
  wire       wrEn     = doWrite && wrHit && wLane_q;
  wire       rdFire   = arvalid && arready;
  wire [5:0] rdIdx    = araddr[7:2];
  wire       rdHit    = (araddr[1:0] == 2'h0) && regHit(rdIdx);
  wire       busy     = state_q != IDLE;

  wire       wrCtrl   = wrEn && (wrIdx == adc_ctrl_pkg::IDX_CTRL);
  wire       wrWin    = wrEn && (wrIdx == adc_ctrl_pkg::IDX_WINMODE);
  wire       wrSamp   = wrEn && (wrIdx == adc_ctrl_pkg::IDX_SAMPEXT);
  wire       wrInSel  = wrEn && (wrIdx == adc_ctrl_pkg::IDX_INSEL);
  wire       wrCmd    = wrEn && (wrIdx == adc_ctrl_pkg::IDX_CMD);
  wire       wrEv     = wrEn && (wrIdx == adc_ctrl_pkg::IDX_EVTRIG);
  wire       wrIrqEn  = wrEn && (wrIdx == adc_ctrl_pkg::IDX_IRQEN);
  wire       wrFlags  = wrEn && (wrIdx == adc_ctrl_pkg::IDX_IRQFLAGS);
  wire       wrLtl    = wrEn && (wrIdx == adc_ctrl_pkg::IDX_LTL);
  wire       wrLth    = wrEn && (wrIdx == adc_ctrl_pkg::IDX_LTH);
  wire       wrHtl    = wrEn && (wrIdx == adc_ctrl_pkg::IDX_HTL);
  wire       wrHth    = wrEn && (wrIdx == adc_ctrl_pkg::IDX_HTH);

  // either result byte counts as a result read
  // a refused (misaligned) read has no side effect
  wire       resultRead = rdFire && rdHit && (rdIdx inside {adc_ctrl_pkg::IDX_RESL,
                                                            adc_ctrl_pkg::IDX_RESH});
  wire       flagRead = rdFire && rdHit && (rdIdx == adc_ctrl_pkg::IDX_IRQFLAGS);

  logic [7:0] rdByte;
  always_comb begin
    rdByte = 8'h00;
    unique case (rdIdx)
      adc_ctrl_pkg::IDX_CTRL:     rdByte[adc_ctrl_pkg::BIT_CONTINUOUS] = continuous_q;
      adc_ctrl_pkg::IDX_WINMODE:  rdByte[2:0] = winMode_q;
      adc_ctrl_pkg::IDX_SAMPEXT:  rdByte[4:0] = sampExt_q;
      adc_ctrl_pkg::IDX_INSEL:    rdByte[4:0] = inSel_q;
      adc_ctrl_pkg::IDX_CMD:      rdByte[adc_ctrl_pkg::BIT_START] = busy;
      adc_ctrl_pkg::IDX_EVTRIG:   rdByte[adc_ctrl_pkg::BIT_EVSTART] = evStart_q;
      adc_ctrl_pkg::IDX_IRQEN:    rdByte[1:0] = irqEn_q;
      adc_ctrl_pkg::IDX_IRQFLAGS: rdByte[1:0] = flags_q;
      adc_ctrl_pkg::IDX_RESL:     rdByte = result_q[7:0];
      adc_ctrl_pkg::IDX_RESH:     rdByte = result_q[15:8];
      adc_ctrl_pkg::IDX_LTL:      rdByte = lowThr_q[7:0];
      adc_ctrl_pkg::IDX_LTH:      rdByte = lowThr_q[15:8];
      adc_ctrl_pkg::IDX_HTL:      rdByte = highThr_q[7:0];
      adc_ctrl_pkg::IDX_HTH:      rdByte = highThr_q[15:8];
      default:                    rdByte = 8'h00;
    endcase
  end

  assign awready = !awHeld_q && !bvalid_q;
  assign wready  = !wHeld_q && !bvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = !rvalid_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wHeld_q  <= 1'b0;
      wByte_q  <= 8'h00;
      wLane_q  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= awaddr;
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld_q <= 1'b1;
        wByte_q <= wdata[7:0];
        wLane_q <= wstrb[0];
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bvalid_q <= 1'b0;
      bresp_q  <= adc_ctrl_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= adc_ctrl_pkg::RESP_OKAY;
    end else begin
      if (doWrite) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wrHit ? adc_ctrl_pkg::RESP_OKAY : adc_ctrl_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
      if (rdFire) begin
        rvalid_q <= 1'b1;
        rdata_q  <= {24'h00_0000, rdHit ? rdByte : 8'h00};
        rresp_q  <= rdHit ? adc_ctrl_pkg::RESP_OKAY : adc_ctrl_pkg::RESP_SLVERR;
      end else if (rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      continuous_q <= 1'b0;
      winMode_q    <= adc_ctrl_pkg::RST_WINMODE;
      sampExt_q    <= adc_ctrl_pkg::RST_SAMPEXT;
      inSel_q      <= adc_ctrl_pkg::RST_INSEL;
      evStart_q    <= 1'b0;
      irqEn_q      <= adc_ctrl_pkg::RST_IRQ;
      lowThr_q     <= adc_ctrl_pkg::RST_THRESH;
      highThr_q    <= adc_ctrl_pkg::RST_THRESH;
    end else begin
      if (wrCtrl)  continuous_q <= wByte_q[adc_ctrl_pkg::BIT_CONTINUOUS];
      if (wrWin)   winMode_q    <= wByte_q[2:0];
      if (wrSamp)  sampExt_q    <= wByte_q[4:0];
      if (wrInSel) inSel_q      <= wByte_q[4:0];
      if (wrEv)    evStart_q    <= wByte_q[adc_ctrl_pkg::BIT_EVSTART];
      if (wrIrqEn) irqEn_q      <= wByte_q[1:0];
      if (wrLtl)   lowThr_q[7:0]   <= wByte_q;
      if (wrLth)   lowThr_q[15:8]  <= wByte_q;
      if (wrHtl)   highThr_q[7:0]  <= wByte_q;
      if (wrHth)   highThr_q[15:8] <= wByte_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // conversion sequencer

  wire tick      = divCnt_q == DIV_W'(CLK_DIV - 1);
  wire cmdStart  = wrCmd && wByte_q[adc_ctrl_pkg::BIT_START];
  wire evTrig    = startEvent && evStart_q;
  wire launch    = !busy && (cmdStart || evTrig);
  wire lastSamp  = (state_q == SAMPLE) && tick && (phaseCnt_q == sample_extend_q - 6'h01);
  wire done      = (state_q == CONVERT) && tick && (phaseCnt_q == CONV_LAST);
  // thresholds see only the finished accumulated value
  wire matchNow  = winMatch(winMode_q, convResult, lowThr_q, highThr_q);
  // a new start also re-latches the selector; mid-run writes wait
  wire relatch   = launch || (done && continuous_q);
  wire [5:0] sampLenNext = 6'(adc_ctrl_pkg::SAMPLE_BASE_CYCLES) + {1'b0, sampExt_q};

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      divCnt_q <= '0;
    end else begin
      divCnt_q <= tick ? '0 : divCnt_q + DIV_W'(1);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q    <= IDLE;
      phaseCnt_q <= 6'h00;
      sample_extend_q  <= 6'(adc_ctrl_pkg::SAMPLE_BASE_CYCLES);
      chan_q     <= adc_ctrl_pkg::RST_INSEL;
      result_q   <= 16'h0000;
    end else begin
      if (relatch) begin
        state_q    <= SAMPLE;
        phaseCnt_q <= 6'h00;
        sample_extend_q  <= sampLenNext;
        chan_q     <= inSel_q;
      end else if (lastSamp) begin
        state_q    <= CONVERT;
        phaseCnt_q <= 6'h00;
      end else if (done) begin
        state_q    <= IDLE;
      end else if (busy && tick) begin
        phaseCnt_q <= phaseCnt_q + 6'h01;
      end
      if (done) result_q <= convResult;
    end
  end

  assign inputSelect = chan_q;
  assign inputLegal  = chanLegal(chan_q);
  assign sampling    = state_q == SAMPLE;
  assign converting  = busy;
  assign convDone    = done;

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt flags; a completion in the clearing cycle wins

  wire       rdClr  = resultRead || flagRead;
  wire [1:0] w1c    = wrFlags ? wByte_q[1:0] : 2'h0;
  wire [1:0] clrVec = w1c | {2{rdClr}};

  always_comb begin
    flags_d.resultReady = done ||
                          (flags_q.resultReady && !clrVec[adc_ctrl_pkg::BIT_RREADY]);
    flags_d.windowMatch = (done && matchNow) ||
                          (flags_q.windowMatch && !clrVec[adc_ctrl_pkg::BIT_WMATCH]);
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      flags_q <= adc_ctrl_pkg::RST_IRQ;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign irq = |(flags_q & irqEn_q);

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  logic [6:0] tickCnt_q;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tickCnt_q <= 7'h00;
    end else if (relatch) begin
      tickCnt_q <= 7'h00;
    end else if (busy && tick) begin
      tickCnt_q <= tickCnt_q + 7'h01;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  matchSets_a: assert property (done && matchNow |=> flags_q.windowMatch)
    else $error("window match flag not set on matching result");
  noMatch_a: assert property (done && !matchNow && !flags_q.windowMatch |=>
    !flags_q.windowMatch)
    else $error("window match flag set without match");
  readySets_a: assert property (done |=> flags_q.resultReady)
    else $error("result ready flag not set on completion");
  oneClears_a: assert property (wrFlags && wByte_q[0] && !done |=>
    !flags_q.resultReady)
    else $error("one write did not clear result ready");
  zeroKeeps_a: assert property (wrFlags && !wByte_q[0] && !rdClr &&
    flags_q.resultReady |=> flags_q.resultReady)
    else $error("zero write changed result ready");
  resultClr_a: assert property (resultRead && !done |=> !flags_q.windowMatch)
    else $error("result read did not clear window match");
  busyRead_a: assert property (rdFire && rdIdx == adc_ctrl_pkg::IDX_CMD |=>
    rdata_q[0] == $past(busy))
    else $error("start bit read does not show busy");
  eventGate_a: assert property (!busy && startEvent && !evStart_q && !cmdStart
    |=> !busy)
    else $error("disabled event started a conversion");
  convLength_a: assert property (done |->
    tickCnt_q == 7'({1'b0, sample_extend_q} + 7'(CONV_CYCLES) - 7'h01))
    else $error("conversion length wrong for sample extension");
  sample_extend_a: assert property (lastSamp |-> tickCnt_q == 7'({1'b0, sample_extend_q} - 7'h01))
    else $error("sampling phase length wrong");
  chanHold_a: assert property (busy && !done |=> $stable(chan_q))
    else $error("input selection changed mid conversion");
  continuous_conversion_a: assert property (done && continuous_q |=> state_q == SAMPLE)
    else $error("continuous mode did not restart");
  irqRaise_a: assert property (done && irqEn_q.resultReady |=> irq)
    else $error("interrupt not raised for enabled flag");

  freeRunDone_c: cover property (done && continuous_q ##1 busy);
  windowHit_c:   cover property (done && matchNow && winMode_q == adc_ctrl_pkg::WIN_INSIDE);
  eventStart_c:  cover property (!busy && evTrig ##1 busy);

endmodule

// >>> sim/adc_window_trigger_irq_ctrl_tb_top.sv
module adc_window_trigger_irq_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV  = 2;
  localparam int CONV = 8;
  // clocks from the return of start to the completion pulse, sample extension zero
  localparam int BASE = (adc_ctrl_pkg::SAMPLE_BASE_CYCLES + CONV - 1) * DIV;
  typedef struct packed {
    logic [2:0]  mode;
    logic [15:0] value;
    logic [1:0]  flags;
  } row_s;
  logic        clock      = 1'b0;
  logic        reset      = 1'b1;
  logic [7:0]  awaddr     = 8'h00;
  logic        awvalid    = 1'b0;
  logic [31:0] wdata      = 32'h00000000;
  logic        wvalid     = 1'b0;
  logic [7:0]  araddr     = 8'h00;
  logic        arvalid    = 1'b0;
  logic        startEvent = 1'b0;
  logic [15:0] convResult = 16'h0000;
  logic        awready, wready, bvalid, arready, rvalid, sampling, converting, convDone, irq;
  logic        inputLegal;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rdata, rdv;
  logic [4:0]  inputSelect;
  int          errCount   = 0;
  int          checkCount = 0;
  int          n, t0, t1;
  // mode, result, flags expected; thresholds are 0x0100 and 0x0200, equal values never match
  row_s rows [10] = '{'{3'h0, 16'h0050, 2'h1}, '{3'h1, 16'h00ff, 2'h3}, '{3'h1, 16'h0100, 2'h1},
    '{3'h2, 16'h0201, 2'h3}, '{3'h2, 16'h0200, 2'h1}, '{3'h3, 16'h0101, 2'h3},
    '{3'h3, 16'h0100, 2'h1}, '{3'h4, 16'h0300, 2'h3}, '{3'h4, 16'h0150, 2'h1},
    '{3'h5, 16'h0000, 2'h1}};
  always #4 clock = ~clock;
  adc_window_trigger_irq_ctrl #(.CLK_DIV(DIV), .CONV_CYCLES(CONV)) u_dut (
    .clock(clock), .reset(reset), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1), .startEvent(startEvent),
    .convResult(convResult), .inputSelect(inputSelect), .inputLegal(inputLegal),
    .sampling(sampling), .converting(converting), .convDone(convDone), .irq(irq));
  //////////////////////////////////////////////////////////////////////////////
  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bound(input int cnt, input int lim);
    if (cnt >= lim) begin
      chk("wait bound", 32'h0, 32'h1);
      wrapUp();
    end
  endtask
  // ready is combinational, so it is looked at mid-cycle and acted on at the next edge
  task automatic wr(input logic [5:0] idx, input logic [7:0] val);
    logic pendA, pendW, takeA, takeW;
    int   k;
    k = 0;
    pendA = 1'b1;
    pendW = 1'b1;
    @(posedge clock);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h000000, val};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(negedge clock);
      takeA = pendA & awready;
      takeW = pendW & wready;
      @(posedge clock);
      if (takeA) awvalid <= 1'b0;
      if (takeW) wvalid <= 1'b0;
      pendA = pendA & !takeA;
      pendW = pendW & !takeW;
      k++;
    end while ((pendA | pendW) && k < 50);
    bound(k, 50);
    do begin
      @(negedge clock);
      k++;
    end while (!bvalid && k < 100);
    bound(k, 100);
    rsp = bresp;
    @(posedge clock);
  endtask
  task automatic rd(input logic [5:0] idx);
    int k;
    k = 0;
    @(posedge clock);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    do begin
      @(negedge clock);
      k++;
    end while (!arready && k < 50);
    bound(k, 50);
    @(posedge clock);
    arvalid <= 1'b0;
    do begin
      @(negedge clock);
      k++;
    end while (!rvalid && k < 100);
    bound(k, 100);
    rdv = rdata;
    rsp = rresp;
    @(posedge clock);
  endtask
  task automatic start(input logic [15:0] value);
    @(posedge clock);
    convResult <= value;
    wr(adc_ctrl_pkg::IDX_CMD, 8'h01);
  endtask
  task automatic waitDone(output int cnt);
    cnt = 0;
    do begin
      @(negedge clock);
      cnt++;
    end while (!convDone && cnt < 2000);
    bound(cnt, 2000);
    @(posedge clock);
  endtask
  task automatic pulseEvent();
    @(posedge clock);
    startEvent <= 1'b1;
    @(posedge clock);
    startEvent <= 1'b0;
    @(negedge clock);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    for (int i = 4; i < 12; i++) begin
      rd(6'(i));
      chk("reset value", 32'h0, rdv);
    end
    rd(6'h3f);
    chk("unmapped read resp", 32'(adc_ctrl_pkg::RESP_SLVERR), 32'(rsp));
    wr(6'h3f, 8'hff);
    chk("unmapped write resp", 32'(adc_ctrl_pkg::RESP_SLVERR), 32'(rsp));
    wr(adc_ctrl_pkg::IDX_LTH, 8'h01);
    wr(adc_ctrl_pkg::IDX_HTH, 8'h02);
    foreach (rows[i]) begin
      wr(adc_ctrl_pkg::IDX_WINMODE, {5'h00, rows[i].mode});
      start(rows[i].value);
      waitDone(n);
      rd(adc_ctrl_pkg::IDX_IRQFLAGS);
      chk("flags", {30'h0, rows[i].flags}, rdv);
      rd(adc_ctrl_pkg::IDX_RESL);
      chk("result low", {24'h0, rows[i].value[7:0]}, rdv);
      rd(adc_ctrl_pkg::IDX_RESH);
      chk("result high", {24'h0, rows[i].value[15:8]}, rdv);
    end
    wr(adc_ctrl_pkg::IDX_INSEL, 8'h1d);
    start(16'h0000);
    wr(adc_ctrl_pkg::IDX_INSEL, 8'h05);
    rd(adc_ctrl_pkg::IDX_CMD);
    chk("busy bit", 32'h1, rdv);
    chk("held select", 32'h1d, inputSelect);
    chk("select legal", 32'h1, inputLegal);
    waitDone(n);
    rd(adc_ctrl_pkg::IDX_CMD);
    chk("busy cleared", 32'h0, rdv);
    wr(adc_ctrl_pkg::IDX_INSEL, 8'h0c);
    start(16'h0000);
    chk("reserved select", 32'h0c, inputSelect);
    chk("reserved legal", 32'h0, inputLegal);
    waitDone(n);
    pulseEvent();
    chk("event ignored", 32'h0, converting);
    wr(adc_ctrl_pkg::IDX_EVTRIG, 8'h01);
    pulseEvent();
    chk("event start", 32'h1, converting);
    chk("event sampling", 32'h1, sampling);
    waitDone(n);
    // the free-running divider makes each count vary by one clock
    start(16'h0000);
    waitDone(t0);
    chk("base length", 32'h1, 32'(t0 >= BASE && t0 <= BASE + DIV - 1));
    wr(adc_ctrl_pkg::IDX_SAMPEXT, 8'h05);
    start(16'h0000);
    waitDone(t1);
    chk("extend delay", 32'h1, 32'(t1 - t0 >= 5 * DIV - 1 && t1 - t0 <= 5 * DIV + 1));
    rd(adc_ctrl_pkg::IDX_IRQFLAGS);
    wr(adc_ctrl_pkg::IDX_IRQEN, 8'h02);
    wr(adc_ctrl_pkg::IDX_WINMODE, 8'h01);
    start(16'h0000);
    waitDone(n);
    @(negedge clock);
    chk("irq match", 32'h1, irq);
    wr(adc_ctrl_pkg::IDX_IRQFLAGS, 8'h01);
    wr(adc_ctrl_pkg::IDX_IRQFLAGS, 8'h00);
    @(negedge clock);
    chk("irq kept", 32'h1, irq);
    rd(adc_ctrl_pkg::IDX_RESH);
    @(negedge clock);
    chk("irq read clear", 32'h0, irq);
    wr(adc_ctrl_pkg::IDX_IRQEN, 8'h01);
    start(16'h0000);
    waitDone(n);
    @(negedge clock);
    chk("irq ready", 32'h1, irq);
    wr(adc_ctrl_pkg::IDX_IRQFLAGS, 8'h01);
    @(negedge clock);
    chk("irq write clear", 32'h0, irq);
    wr(adc_ctrl_pkg::IDX_IRQEN, 8'h00);
    start(16'h0000);
    waitDone(n);
    @(negedge clock);
    chk("irq masked", 32'h0, irq);
    rd(adc_ctrl_pkg::IDX_IRQFLAGS);
    chk("flags masked", 32'h3, rdv);
    wr(adc_ctrl_pkg::IDX_CTRL, 8'h02);
    start(16'h0000);
    waitDone(n);
    @(negedge clock);
    chk("free run", 32'h1, converting);
    waitDone(n);
    wr(adc_ctrl_pkg::IDX_CTRL, 8'h00);
    waitDone(n);
    @(negedge clock);
    chk("free run stop", 32'h0, converting);
    start(16'h0000);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    chk("reset idle", 32'h0, {converting, irq});
    rd(adc_ctrl_pkg::IDX_WINMODE);
    chk("reset mode", 32'h0, rdv);
    wrapUp();
  end
endmodule
